// >>> hw/iodt_cpu_end.sv
// Processor dispatch end: table address mapping, instructions, irq entry
`timescale 1ns/10ps
module iodt_cpu_end
(
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    iodt_link_if.cpu                         lnk,
    input  wire logic                        instr_valid,
    input  wire iodt_pkg::iodt_op_t          instr_op,
    input  wire logic [iodt_pkg::DEV_W-1:0]  instr_dev,
    input  wire logic [iodt_pkg::WORD_W-1:0] tos_in,
    input  wire logic [iodt_pkg::ADDR_W-1:0] prog_start,
    output logic                             instr_busy,
    output logic                             instr_done,
    output logic                             instr_nodev,
    output logic      [iodt_pkg::WORD_W-1:0] tos_out,
    output logic                             tos_push,
    output logic                             mem_we,
    output logic      [iodt_pkg::ADDR_W-1:0] mem_addr,
    output logic      [iodt_pkg::WORD_W-1:0] mem_wdata,
    output logic                             int_enter,
    output logic      [iodt_pkg::DEV_W-1:0]  int_dev,
    output logic      [iodt_pkg::ADDR_W-1:0] int_data_ptr_addr
);
    import iodt_pkg::*;

    iodt_state_t          st_r, st_nxt;
    iodt_op_t             op_r, op_nxt;
    logic [DEV_W-1:0]     dev_r, dev_nxt;
    logic [WORD_W-1:0]    wd_r, wd_nxt;
    logic [ADDR_W-1:0]    pa_r, pa_nxt;
    logic                 req_r, req_nxt;
    logic                 done_r, done_nxt;
    logic                 nodev_r, nodev_nxt;
    logic [WORD_W-1:0]    tos_r, tos_nxt;
    logic                 push_r, push_nxt;
    logic                 we_r, we_nxt;
    logic [ADDR_W-1:0]    ma_r, ma_nxt;
    logic [WORD_W-1:0]    mwd_r, mwd_nxt;
    logic                 ie_r, ie_nxt;
    logic [DEV_W-1:0]     idev_r, idev_nxt;
    logic [ADDR_W-1:0]    iptr_r, iptr_nxt;
    logic                 iack_r, iack_nxt;
    logic                 bsy_r, bsy_nxt;
    logic [CTRL_IDX_W-1:0] iidx_r, iidx_nxt;
    logic [ADDR_W-1:0]    entry_addr;
    logic                 dev_ok;
    logic                 win_found;
    logic [CTRL_IDX_W-1:0] win_idx;

    assign lnk.req         = req_r;
    assign lnk.op          = op_r;
    assign lnk.dev         = dev_r;
    assign lnk.wdata       = wd_r;
    assign lnk.prog_addr   = pa_r;
    assign lnk.irq_ack     = iack_r;
    assign lnk.irq_ack_idx = iidx_r;
    assign instr_busy      = bsy_r;
    assign instr_done      = done_r;
    assign instr_nodev     = nodev_r;
    assign tos_out         = tos_r;
    assign tos_push        = push_r;
    assign mem_we          = we_r;
    assign mem_addr        = ma_r;
    assign mem_wdata       = mwd_r;
    assign int_enter       = ie_r;
    assign int_dev         = idev_r;
    assign int_data_ptr_addr = iptr_r;

    ////////////////////////////////////////////////////////////////////////
    // Controller number to table entry, with range check
    assign entry_addr = ADDR_W'(instr_dev) << ENTRY_SHIFT;
    assign dev_ok     = (instr_dev >= DEV_LOWEST)
                        && ((entry_addr + 16'h0003) <= TABLE_HI_ADDR)
                        && (instr_dev < DEV_W'(CTRL_BASE_NUM + NUM_CTRL));

    // Lowest pending controller number wins
    always_comb
    begin
        win_found = 1'b0;
        win_idx   = '0;
        for (int i = NUM_CTRL - 1; i >= 0; i--)
        begin
            if (lnk.irq[i])
            begin
                win_found = 1'b1;
                win_idx   = CTRL_IDX_W'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt    = st_r;
        op_nxt    = op_r;
        dev_nxt   = dev_r;
        wd_nxt    = wd_r;
        pa_nxt    = pa_r;
        req_nxt   = req_r;
        done_nxt  = 1'b0;
        nodev_nxt = 1'b0;
        tos_nxt   = tos_r;
        push_nxt  = 1'b0;
        we_nxt    = 1'b0;
        ma_nxt    = ma_r;
        mwd_nxt   = mwd_r;
        ie_nxt    = 1'b0;
        idev_nxt  = idev_r;
        iptr_nxt  = iptr_r;
        iack_nxt  = 1'b0;
        iidx_nxt  = iidx_r;
        if (win_found && !iack_r)
        begin
            ie_nxt   = 1'b1;
            iack_nxt = 1'b1;
            iidx_nxt = win_idx;
            idev_nxt = DEV_W'(CTRL_BASE_NUM) + DEV_W'(win_idx);
            iptr_nxt = (ADDR_W'(DEV_W'(CTRL_BASE_NUM) + DEV_W'(win_idx)) << ENTRY_SHIFT)
                       + ADDR_W'(PTR_WORD_OFS);
        end
        case (st_r)
            IODT_ST_IDLE:
            begin
                if (instr_valid)
                begin
                    if (!dev_ok)
                    begin
                        nodev_nxt = 1'b1;
                        done_nxt  = 1'b1;
                    end
                    else
                    begin
                        op_nxt  = instr_op;
                        dev_nxt = instr_dev;
                        wd_nxt  = tos_in;
                        pa_nxt  = prog_start;
                        st_nxt  = IODT_ST_SEND;
                        if (instr_op == IODT_OP_SCP)
                        begin
                            we_nxt  = 1'b1;
                            ma_nxt  = entry_addr;
                            mwd_nxt = prog_start;
                        end
                    end
                end
            end
            IODT_ST_SEND:
            begin
                req_nxt = 1'b1;
                st_nxt  = IODT_ST_WAIT;
            end
            IODT_ST_WAIT:
            begin
                if (lnk.ack)
                begin
                    req_nxt = 1'b0;
                    st_nxt  = IODT_ST_DONE;
                    if (op_r == IODT_OP_RD || op_r == IODT_OP_TST || op_r == IODT_OP_READ_DEVICE_MASK_INSTR)
                    begin
                        tos_nxt  = lnk.rdata;
                        push_nxt = 1'b1;
                    end
                end
            end
            IODT_ST_DONE:
            begin
                done_nxt = 1'b1;
                st_nxt   = IODT_ST_IDLE;
            end
            default:
            begin
                st_nxt = IODT_ST_IDLE;
            end
        endcase
        bsy_nxt = (st_nxt != IODT_ST_IDLE);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r    <= IODT_ST_IDLE;
            op_r    <= IODT_OP_CMD;
            dev_r   <= '0;
            wd_r    <= WORD_ZERO;
            pa_r    <= WORD_ZERO;
            req_r   <= 1'b0;
            done_r  <= 1'b0;
            nodev_r <= 1'b0;
            tos_r   <= WORD_ZERO;
            push_r  <= 1'b0;
            we_r    <= 1'b0;
            ma_r    <= WORD_ZERO;
            mwd_r   <= WORD_ZERO;
            ie_r    <= 1'b0;
            idev_r  <= '0;
            iptr_r  <= WORD_ZERO;
            iack_r  <= 1'b0;
            iidx_r  <= '0;
            bsy_r   <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            op_r    <= op_nxt;
            dev_r   <= dev_nxt;
            wd_r    <= wd_nxt;
            pa_r    <= pa_nxt;
            req_r   <= req_nxt;
            done_r  <= done_nxt;
            nodev_r <= nodev_nxt;
            tos_r   <= tos_nxt;
            push_r  <= push_nxt;
            we_r    <= we_nxt;
            ma_r    <= ma_nxt;
            mwd_r   <= mwd_nxt;
            ie_r    <= ie_nxt;
            idev_r  <= idev_nxt;
            iptr_r  <= iptr_nxt;
            iack_r  <= iack_nxt;
            iidx_r  <= iidx_nxt;
            bsy_r   <= bsy_nxt;
        end
    end
endmodule

// >>> hw/iodt_pkg.sv
// Shared constants and types for the controller table dispatch link
package iodt_pkg;
    localparam int          WORD_W         = 16;
    localparam int          DEV_W          = 8;
    localparam int          ADDR_W         = 16;
    localparam int          ENTRY_SHIFT    = 2;
    localparam int          NUM_CTRL       = 8;
    localparam int          CTRL_IDX_W     = 3;
    localparam int          CTRL_BASE_NUM  = 3;
    localparam logic [7:0]  DEV_LOWEST     = 8'h03;
    localparam logic [15:0] TABLE_LO_ADDR  = 16'h000C;
    localparam logic [15:0] TABLE_HI_ADDR  = 16'h01FF;
    localparam logic [1:0]  PTR_WORD_OFS   = 2'h2;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    typedef enum logic [3:0]
    {
        IODT_OP_CMD  = 4'b0000,
        IODT_OP_SIN  = 4'b0001,
        IODT_OP_SED  = 4'b0010,
        IODT_OP_SCP  = 4'b0011,
        IODT_OP_RD   = 4'b0100,
        IODT_OP_WR   = 4'b0101,
        IODT_OP_TST  = 4'b0110,
        IODT_OP_CTL  = 4'b0111,
        IODT_OP_SET_DEVICE_MASK_INSTR = 4'b1000,
        IODT_OP_READ_DEVICE_MASK_INSTR = 4'b1001
    } iodt_op_t;

    typedef enum logic [1:0]
    {
        IODT_ST_IDLE = 2'b00,
        IODT_ST_SEND = 2'b01,
        IODT_ST_WAIT = 2'b10,
        IODT_ST_DONE = 2'b11
    } iodt_state_t;

    typedef enum logic [1:0]
    {
        IODT_CH_IDLE = 2'b00,
        IODT_CH_XFER = 2'b01,
        IODT_CH_IRQ  = 2'b10
    } iodt_ch_state_t;
endpackage

// >>> hw/iodt_link_if.sv
// Link between processor dispatch end and controller/channel end
`timescale 1ns/10ps
interface iodt_link_if;
    import iodt_pkg::*;
    logic               req;
    iodt_op_t           op;
    logic [DEV_W-1:0]   dev;
    logic [WORD_W-1:0]  wdata;
    logic [ADDR_W-1:0]  prog_addr;
    logic               ack;
    logic [WORD_W-1:0]  rdata;
    logic [NUM_CTRL-1:0] irq;
    logic [CTRL_IDX_W-1:0] irq_ack_idx;
    logic               irq_ack;

    modport cpu
    (
        output req, op, dev, wdata, prog_addr, irq_ack_idx, irq_ack,
        input  ack, rdata, irq
    );
    modport ctrl
    (
        input  req, op, dev, wdata, prog_addr, irq_ack_idx, irq_ack,
        output ack, rdata, irq
    );
endinterface

// >>> hw/iodt_ctrl_end.sv
// Controller and channel end: runs channel programs, answers direct words
`timescale 1ns/10ps
module iodt_ctrl_end
#(
    parameter int XFER_LEN = 4
)
(
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    iodt_link_if.ctrl                          lnk,
    input  wire logic [iodt_pkg::WORD_W-1:0]   dev_rdata,
    output logic      [iodt_pkg::WORD_W-1:0]   dev_wdata,
    output logic                               dev_wstb,
    output logic      [iodt_pkg::NUM_CTRL-1:0] dev_busy
);
    import iodt_pkg::*;

    logic                 ack_r, ack_nxt;
    logic [WORD_W-1:0]    rdata_r, rdata_nxt;
    logic [WORD_W-1:0]    dwdata_r, dwdata_nxt;
    logic                 dwstb_r, dwstb_nxt;
    logic [NUM_CTRL-1:0]  irq_r, irq_nxt;
    logic [NUM_CTRL-1:0]  busy_r, busy_nxt;
    logic [7:0]           cnt_r [NUM_CTRL];
    logic [7:0]           cnt_nxt [NUM_CTRL];
    logic [DEV_W-1:0]     idx;

    assign lnk.ack   = ack_r;
    assign lnk.rdata = rdata_r;
    assign lnk.irq   = irq_r;
    assign dev_wdata = dwdata_r;
    assign dev_wstb  = dwstb_r;
    assign dev_busy  = busy_r;
    assign idx       = DEV_W'(lnk.dev - DEV_LOWEST);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ack_nxt    = 1'b0;
        rdata_nxt  = rdata_r;
        dwdata_nxt = dwdata_r;
        dwstb_nxt  = 1'b0;
        irq_nxt    = irq_r;
        busy_nxt   = busy_r;
        // Clear first so that a fresh request in the same cycle wins
        if (lnk.irq_ack)
        begin
            irq_nxt[lnk.irq_ack_idx] = 1'b0;
        end
        for (int i = 0; i < NUM_CTRL; i++)
        begin
            cnt_nxt[i] = cnt_r[i];
            // Block moves one word per cycle, then the program asks for irq
            if (busy_r[i])
            begin
                if (cnt_r[i] == 8'h00)
                begin
                    busy_nxt[i] = 1'b0;
                    irq_nxt[i]  = 1'b1;
                end
                else
                begin
                    cnt_nxt[i] = cnt_r[i] - 8'h01;
                end
            end
        end
        if (lnk.req && !ack_r && idx < DEV_W'(NUM_CTRL))
        begin
            ack_nxt = 1'b1;
            case (lnk.op)
                IODT_OP_SCP:
                begin
                    busy_nxt[idx[CTRL_IDX_W-1:0]] = 1'b1;
                    cnt_nxt[idx[CTRL_IDX_W-1:0]]  = 8'(XFER_LEN - 1);
                end
                IODT_OP_RD, IODT_OP_TST, IODT_OP_READ_DEVICE_MASK_INSTR:
                begin
                    rdata_nxt = dev_rdata;
                end
                default:
                begin
                    dwdata_nxt = lnk.wdata;
                    dwstb_nxt  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ack_r    <= 1'b0;
            rdata_r  <= WORD_ZERO;
            dwdata_r <= WORD_ZERO;
            dwstb_r  <= 1'b0;
            irq_r    <= '0;
            busy_r   <= '0;
            for (int i = 0; i < NUM_CTRL; i++)
            begin
                cnt_r[i] <= 8'h00;
            end
        end
        else
        begin
            ack_r    <= ack_nxt;
            rdata_r  <= rdata_nxt;
            dwdata_r <= dwdata_nxt;
            dwstb_r  <= dwstb_nxt;
            irq_r    <= irq_nxt;
            busy_r   <= busy_nxt;
            cnt_r    <= cnt_nxt;
        end
    end
endmodule

// >>> dv/iodt_link_checker.sv
// Protocol checker for the dispatch link between the two ends
`timescale 1ns/10ps
module iodt_link_checker
(
    input wire logic                              core_clk,
    input wire logic                              rst,
    input wire logic                              req,
    input wire iodt_pkg::iodt_op_t                op,
    input wire logic [iodt_pkg::DEV_W-1:0]        dev,
    input wire logic [iodt_pkg::WORD_W-1:0]       wdata,
    input wire logic [iodt_pkg::ADDR_W-1:0]       prog_addr,
    input wire logic                              ack,
    input wire logic [iodt_pkg::WORD_W-1:0]       rdata,
    input wire logic [iodt_pkg::NUM_CTRL-1:0]     irq,
    input wire logic [iodt_pkg::CTRL_IDX_W-1:0]   irq_ack_idx,
    input wire logic                              irq_ack
);
    import iodt_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without a request");
    chk_ack_prompt: assert property ($rose(req) |-> ##[1:2] ack)
        else $error("request not answered in time");
    chk_req_hold: assert property (req && !ack |=> req && $stable(op) && $stable(dev)
        && $stable(wdata) && $stable(prog_addr))
        else $error("request changed before ack");
    chk_dev_range: assert property (req |-> dev >= DEV_LOWEST && dev < DEV_LOWEST + NUM_CTRL)
        else $error("request to a controller that does not exist");
    chk_irq_valid: assert property (irq_ack |-> irq[irq_ack_idx])
        else $error("irq acknowledged while not pending");
    chk_irq_clear: assert property (irq_ack |=> !irq[$past(irq_ack_idx)])
        else $error("irq not cleared after acknowledge");
    chk_irq_prio: assert property (irq_ack |->
        ($past(irq) & ((NUM_CTRL'(1) << irq_ack_idx) - NUM_CTRL'(1))) == '0)
        else $error("lower numbered irq was passed over");
    chk_irq_once: assert property (irq_ack |=> !irq_ack)
        else $error("irq acknowledge repeated");
    ////////////////////////////////////////////////////////////////////////////
    cov_start: cover property (ack && op == IODT_OP_SCP);
    cov_read: cover property (ack && op == IODT_OP_RD);
    cov_irq: cover property (irq_ack);
    cov_two_irq: cover property ($countones(irq) > 1);
endmodule

// >>> dv/io_device_table_dispatch_tb_top.sv
// Testbench joining the processor end and the controller end
`timescale 1ns/10ps
module io_device_table_dispatch_tb_top;
    import iodt_pkg::*;
    localparam int XLEN = 6;
    logic core_clk = 0, rst = 1, instr_valid = 0;
    iodt_op_t instr_op = IODT_OP_CMD;
    logic [7:0] instr_dev = 0, int_dev;
    logic [15:0] tos_in = 0, prog_start = 0, dev_rdata = 0;
    logic instr_busy, instr_done, instr_nodev, tos_push, mem_we, dev_wstb, int_enter;
    logic [15:0] tos_out, mem_addr, mem_wdata, dev_wdata, int_data_ptr_addr;
    logic [7:0] dev_busy;
    int miscompares = 0, checked = 0;
    int starts [256], ints [256];
    int busy_cyc [NUM_CTRL];
    always #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    iodt_link_if u_iodt_link_if ();
    iodt_cpu_end u_iodt_cpu_end (.core_clk(core_clk), .rst(rst), .lnk(u_iodt_link_if),
        .instr_valid(instr_valid), .instr_op(instr_op), .instr_dev(instr_dev),
        .tos_in(tos_in), .prog_start(prog_start), .instr_busy(instr_busy),
        .instr_done(instr_done), .instr_nodev(instr_nodev), .tos_out(tos_out),
        .tos_push(tos_push), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .int_enter(int_enter), .int_dev(int_dev), .int_data_ptr_addr(int_data_ptr_addr));
    iodt_ctrl_end #(.XFER_LEN(XLEN)) u_iodt_ctrl_end (.core_clk(core_clk), .rst(rst),
        .lnk(u_iodt_link_if), .dev_rdata(dev_rdata), .dev_wdata(dev_wdata),
        .dev_wstb(dev_wstb), .dev_busy(dev_busy));
    iodt_link_checker u_iodt_link_checker (.core_clk(core_clk), .rst(rst),
        .req(u_iodt_link_if.req), .op(u_iodt_link_if.op), .dev(u_iodt_link_if.dev),
        .wdata(u_iodt_link_if.wdata), .prog_addr(u_iodt_link_if.prog_addr),
        .ack(u_iodt_link_if.ack), .rdata(u_iodt_link_if.rdata), .irq(u_iodt_link_if.irq),
        .irq_ack_idx(u_iodt_link_if.irq_ack_idx), .irq_ack(u_iodt_link_if.irq_ack));
    ////////////////////////////////////////////////////////////////////////////
    task results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task cmp(string what, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    function logic [15:0] entry(logic [7:0] d);
        return 16'(d) << ENTRY_SHIFT;
    endfunction
    function logic ok_dev(logic [7:0] d);
        return d >= DEV_LOWEST && d < DEV_LOWEST + NUM_CTRL
            && entry(d) + 16'h0003 <= TABLE_HI_ADDR;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // One instruction, with every pulse it causes caught up to done
    task run(iodt_op_t o, logic [7:0] d);
        logic nd, we, pu, ws, dn, ok, rd, wr, bz;
        logic [15:0] a, wd, to, dw;
        {nd, we, pu, ws, dn} = '0;
        ok = ok_dev(d);
        rd = o inside {IODT_OP_RD, IODT_OP_TST, IODT_OP_READ_DEVICE_MASK_INSTR};
        wr = ok && !rd && o != IODT_OP_SCP;
        tos_in = 16'($urandom);
        prog_start = 16'($urandom);
        dev_rdata = 16'($urandom);
        instr_op = o;
        instr_dev = d;
        instr_valid = 1;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge core_clk);
            instr_valid = 0;
            if (k == 0) bz = instr_busy;
            if (instr_nodev === 1'b1) nd = 1;
            if (mem_we === 1'b1) {we, a, wd} = {1'b1, mem_addr, mem_wdata};
            if (tos_push === 1'b1) {pu, to} = {1'b1, tos_out};
            if (dev_wstb === 1'b1) {ws, dw} = {1'b1, dev_wdata};
            if (instr_done === 1'b1) dn = 1;
            if (dn) break;
        end
        if (!dn)
        begin
            miscompares++;
            results();
        end
        cmp("nodev", 16'(!ok), 16'(nd));
        cmp("instr_busy", 16'(ok), 16'(bz));
        cmp("mem_we", 16'(ok && o == IODT_OP_SCP), 16'(we));
        if (ok && o == IODT_OP_SCP)
        begin
            starts[d]++;
            cmp("mem_addr", entry(d), a);
            cmp("mem_wdata", prog_start, wd);
        end
        cmp("tos_push", 16'(ok && rd), 16'(pu));
        if (ok && rd) cmp("tos_out", dev_rdata, to);
        cmp("dev_wstb", 16'(wr), 16'(ws));
        if (wr) cmp("dev_wdata", tos_in, dw);
    endtask
    // Each started controller should stay busy for one block length
    always @(negedge core_clk)
        for (int i = 0; i < NUM_CTRL; i++) busy_cyc[i] += int'(dev_busy[i] === 1'b1);
    always @(negedge core_clk)
        if (int_enter === 1'b1)
        begin
            ints[int_dev]++;
            cmp("int_ptr", entry(int_dev) + 16'(PTR_WORD_OFS), int_data_ptr_addr);
        end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        iodt_op_t o;
        logic [7:0] d;
        logic [7:0] cd [5] = '{8'h00, 8'h02, 8'h0A, 8'h0B, 8'hFF};
        void'($urandom(3));
        repeat (10) @(negedge core_clk);
        rst = 0;
        for (int i = 0; i < 10; i++) run(iodt_op_t'(i), DEV_LOWEST);
        foreach (cd[i])
        begin
            run(IODT_OP_SCP, cd[i]);
            run(IODT_OP_RD, cd[i]);
        end
        repeat (40)
        begin
            o = iodt_op_t'($urandom_range(0, 9));
            d = 8'($urandom_range(0, 12));
            if (o == IODT_OP_SCP && starts[d] != ints[d]) o = IODT_OP_RD;
            run(o, d);
        end
        repeat (80) @(negedge core_clk);
        for (int i = 3; i < 3 + NUM_CTRL; i++)
        begin
            cmp("int_count", 16'(starts[i]), 16'(ints[i]));
            cmp("busy_cycles", 16'(starts[i] * XLEN), 16'(busy_cyc[i - 3]));
        end
        results();
    end
endmodule
